// ==== core/petf_trigger_flags.sv ====
// Event-trigger interrupt and conversion-start flag logic of a PWM block.
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none

module petf_trigger_flags
    import petf_pkg::*;
(
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // Register port.
    input  wire logic [PETF_AW-1:0] reg_addr,
    input  wire logic [PETF_DW-1:0] reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  logic [PETF_DW-1:0] reg_rdata,
    // Selected timer events, one cycle each.
    input  wire logic               irq_event_in,
    input  wire logic               conversion_start_a_event_in,
    input  wire logic               conversion_start_b_event_in,
    // Trigger pulses to the interrupt controller and the converter.
    output var  logic               pwm_irq_output,
    output var  logic               conv_start_a_output,
    output var  logic               conv_start_b_output,
    // Level interrupt from masked sticky flags.
    output var  logic               flag_irq
);

    // Software-owned registers and the event tally.
    petf_word_t sel_q;
    petf_word_t sel_d;
    petf_word_t mask_q;
    petf_word_t mask_d;
    logic [1:0] prd_q;
    logic [1:0] prd_d;
    logic [1:0] tally_q;
    logic [1:0] tally_d;

    // Flag states from the sticky flag cells.
    logic int_flag_q;
    logic conversion_start_a_flag_q;
    logic conversion_start_b_flag_q;

    // Address decode of the register port.
    logic wr_sel;
    logic wr_prescale;
    logic wr_clear;
    logic wr_force;
    logic wr_mask;

    assign wr_sel      = reg_wr && (reg_addr == PETF_SEL_OFS);
    assign wr_prescale = reg_wr && (reg_addr == PETF_PRESCALE_OFS);
    assign wr_clear    = reg_wr && (reg_addr == PETF_CLEAR_OFS);
    assign wr_force    = reg_wr && (reg_addr == PETF_FORCE_OFS);
    assign wr_mask     = reg_wr && (reg_addr == PETF_MASK_OFS);

    // Write-one strobes of the clear and force words; they hold no state.
    logic clr_int;
    logic clr_conversion_start_a;
    logic clr_conversion_start_b;
    logic frc_int_raw;
    logic frc_conversion_start_a;
    logic frc_conversion_start_b;

    assign clr_int     = wr_clear && reg_wdata[PETF_INT_BIT];
    assign clr_conversion_start_a    = wr_clear && reg_wdata[PETF_CONVERSION_START_A_BIT];
    assign clr_conversion_start_b    = wr_clear && reg_wdata[PETF_CONVERSION_START_B_BIT];
    assign frc_int_raw = wr_force && reg_wdata[PETF_INT_BIT];
    assign frc_conversion_start_a    = wr_force && reg_wdata[PETF_CONVERSION_START_A_BIT];
    assign frc_conversion_start_b    = wr_force && reg_wdata[PETF_CONVERSION_START_B_BIT];

    // Enables taken from the select word, same layout as the flags.
    logic irq_en;
    logic conversion_start_a_en;
    logic conversion_start_b_en;

    assign irq_en  = sel_q[PETF_INT_BIT];
    assign conversion_start_a_en = sel_q[PETF_CONVERSION_START_A_BIT];
    assign conversion_start_b_en = sel_q[PETF_CONVERSION_START_B_BIT];

    // Next values of the plain software registers.
    logic [1:0] prd_wdata;

    assign prd_wdata = reg_wdata[PETF_PRD_LSB +: PETF_PRD_W];
    assign sel_d     = wr_sel ? reg_wdata : sel_q;
    assign mask_d    = wr_mask ? (reg_wdata & PETF_FLAG_BITS) : mask_q;
    assign prd_d     = wr_prescale ? prd_wdata : prd_q;

    // Interrupt counting.
    // The counter runs while a period is set, and also in the cycle a new
    // period is written, so an event coinciding with that write is kept.
    logic prd_active;
    logic count_on;
    logic blocked;
    logic at_limit;
    logic tally_inc;
    logic [1:0] tally_sum;

    assign prd_active = (prd_q != PETF_PRD_OFF);
    assign count_on   = prd_active || wr_prescale;
    assign blocked    = !irq_en || int_flag_q;
    assign at_limit   = (tally_q == prd_q);

    // A blocked counter parks at the period value; it also never wraps,
    // because a wrap would silently lose a held-off interrupt.
    assign tally_inc  = irq_event_in && count_on
                        && !(blocked && at_limit)
                        && (tally_q != PETF_TALLY_MAX);
    assign tally_sum  = tally_inc ? (tally_q + PETF_TALLY_ONE) : tally_q;

    // Interrupt firing.
    // Comparing with the present period means a period written equal to
    // the tally fires on the next cycle. A period below the tally is left
    // to software to avoid; here it simply fires on the next cycle as well.
    logic irq_reach;
    logic irq_fire;
    logic frc_int;
    logic irq_pulse_d;
    logic int_set;

    assign irq_reach = prd_active && (tally_sum >= prd_q);
    assign irq_fire  = irq_reach && irq_en && !int_flag_q;

    // A forced interrupt is ignored with period zero.
    assign frc_int   = frc_int_raw && prd_active;

    // The force pulses only when enabled and the flag is clear, but the
    // flag is set by it regardless.
    assign irq_pulse_d = irq_fire
                         || (frc_int && irq_en && !int_flag_q);
    assign int_set     = irq_pulse_d || frc_int;

    // Pending interrupt: held in the parked tally while the flag stands,
    // released by irq_fire once the flag is cleared.
    logic irq_pending;

    assign irq_pending = int_flag_q && irq_en && prd_active
                         && at_limit;

    // Tally clears on every interrupt pulse, otherwise it takes the sum.
    assign tally_d = irq_pulse_d ? PETF_TALLY_RST : tally_sum;

    // Conversion-start pulses ignore their flags, unlike the interrupt.
    logic conversion_start_a_pulse_d;
    logic conversion_start_b_pulse_d;
    logic conversion_start_a_set;
    logic conversion_start_b_set;

    assign conversion_start_a_pulse_d = conversion_start_a_en && (conversion_start_a_event_in || frc_conversion_start_a);
    assign conversion_start_b_pulse_d = conversion_start_b_en && (conversion_start_b_event_in || frc_conversion_start_b);
    assign conversion_start_a_set     = conversion_start_a_pulse_d || frc_conversion_start_a;
    assign conversion_start_b_set     = conversion_start_b_pulse_d || frc_conversion_start_b;

    // Sticky status flags; a set in the clearing cycle survives.
    petf_sticky_flag #(
        .RST_VAL (1'b0)
    ) u_int_flag (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_req  (int_set),
        .clr_req  (clr_int),
        .flag_q   (int_flag_q)
    );

    petf_sticky_flag #(
        .RST_VAL (1'b0)
    ) u_conversion_start_a_flag (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_req  (conversion_start_a_set),
        .clr_req  (clr_conversion_start_a),
        .flag_q   (conversion_start_a_flag_q)
    );

    petf_sticky_flag #(
        .RST_VAL (1'b0)
    ) u_conversion_start_b_flag (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_req  (conversion_start_b_set),
        .clr_req  (clr_conversion_start_b),
        .flag_q   (conversion_start_b_flag_q)
    );

    // Flag word as software sees it; reserved bits read as zero.
    petf_word_t flags_word;
    petf_word_t masked_flags;
    logic       flag_irq_d;

    always_comb
    begin
        flags_word                = PETF_ZERO_WORD;
        flags_word[PETF_INT_BIT]  = int_flag_q;
        flags_word[PETF_CONVERSION_START_A_BIT] = conversion_start_a_flag_q;
        flags_word[PETF_CONVERSION_START_B_BIT] = conversion_start_b_flag_q;
    end

    assign masked_flags = flags_word & mask_q;
    assign flag_irq_d   = |masked_flags;

    // Prescale word: period, live tally and the pending indication.
    petf_word_t prescale_word;

    always_comb
    begin
        prescale_word = PETF_ZERO_WORD;
        prescale_word[PETF_PRD_LSB +: PETF_PRD_W]   = prd_q;
        prescale_word[PETF_TALLY_LSB +: PETF_PRD_W] = tally_q;
        prescale_word[PETF_PENDING_BIT]             = irq_pending;
    end

    // Read selection. Clear and force words, and unmapped addresses,
    // read as zero.
    logic       rd_is_sel;
    logic       rd_is_prescale;
    logic       rd_is_flags;
    logic       rd_is_mask;
    petf_word_t rd_word;
    petf_word_t rdata_d;

    assign rd_is_sel      = (reg_addr == PETF_SEL_OFS);
    assign rd_is_prescale = (reg_addr == PETF_PRESCALE_OFS);
    assign rd_is_flags    = (reg_addr == PETF_FLAGS_OFS);
    assign rd_is_mask     = (reg_addr == PETF_MASK_OFS);

    assign rd_word = rd_is_sel      ? sel_q :
                     rd_is_prescale ? prescale_word :
                     rd_is_flags    ? flags_word :
                     rd_is_mask     ? mask_q :
                                      PETF_ZERO_WORD;

    // Read data stand only in the cycle after the strobe.
    assign rdata_d = reg_rd ? rd_word : PETF_ZERO_WORD;

    // Software registers and the event tally.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_q   <= PETF_SEL_RST;
            mask_q  <= PETF_MASK_RST;
            prd_q   <= PETF_PRD_OFF;
            tally_q <= PETF_TALLY_RST;
        end
        else
        begin
            sel_q   <= sel_d;
            mask_q  <= mask_d;
            prd_q   <= prd_d;
            tally_q <= tally_d;
        end
    end

    // Output pulses come straight from flops; the interrupt is one clock wide, a conversion pulse lasts as long as its event or force.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwm_irq_output      <= 1'b0;
            conv_start_a_output <= 1'b0;
            conv_start_b_output <= 1'b0;
        end
        else
        begin
            pwm_irq_output      <= irq_pulse_d;
            conv_start_a_output <= conversion_start_a_pulse_d;
            conv_start_b_output <= conversion_start_b_pulse_d;
        end
    end

    // Level interrupt and read data registers.
    // The level trails the flags by one cycle; a clear therefore drops
    // it two cycles after the write, which software must tolerate.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flag_irq  <= 1'b0;
            reg_rdata <= PETF_ZERO_WORD;
        end
        else
        begin
            flag_irq  <= flag_irq_d;
            reg_rdata <= rdata_d;
        end
    end

endmodule : petf_trigger_flags

`default_nettype wire

// ==== inc/petf_pkg.sv ====
// Shared constants for the PWM event-trigger flag block.
`default_nettype none

package petf_pkg;

    // Register port widths.
    localparam int unsigned PETF_AW = 8;
    localparam int unsigned PETF_DW = 16;

    // Byte offsets of the registers, one aligned word each.
    localparam logic [7:0] PETF_SEL_OFS      = 8'h00;
    localparam logic [7:0] PETF_PRESCALE_OFS = 8'h04;
    localparam logic [7:0] PETF_FLAGS_OFS    = 8'h08;
    localparam logic [7:0] PETF_CLEAR_OFS    = 8'h0C;
    localparam logic [7:0] PETF_FORCE_OFS    = 8'h10;
    localparam logic [7:0] PETF_MASK_OFS     = 8'h14;

    // Bit layout shared by flags, clear, force, select and mask words.
    localparam int unsigned PETF_INT_BIT  = 0;
    localparam int unsigned PETF_CONVERSION_START_A_BIT = 2;
    localparam int unsigned PETF_CONVERSION_START_B_BIT = 3;

    // Prescale word layout.
    localparam int unsigned PETF_PRD_LSB     = 0;
    localparam int unsigned PETF_PRD_W       = 2;
    localparam int unsigned PETF_TALLY_LSB   = 2;
    localparam int unsigned PETF_PENDING_BIT = 4;

    // Period and tally encodings.
    localparam logic [1:0] PETF_PRD_OFF   = 2'h0;
    localparam logic [1:0] PETF_TALLY_RST = 2'h0;
    localparam logic [1:0] PETF_TALLY_MAX = 2'h3;
    localparam logic [1:0] PETF_TALLY_ONE = 2'h1;

    // Reset values and the set of implemented flag bits.
    localparam logic [15:0] PETF_SEL_RST   = 16'h0000;
    localparam logic [15:0] PETF_MASK_RST  = 16'h0000;
    localparam logic [15:0] PETF_ZERO_WORD = 16'h0000;
    localparam logic [15:0] PETF_FLAG_BITS = 16'h000D;

    // One register word.
    typedef logic [PETF_DW-1:0] petf_word_t;

endpackage : petf_pkg

`default_nettype wire

// ==== core/petf_sticky_flag.sv ====
// Sticky status flag with priority of set over clear.
`default_nettype none

module petf_sticky_flag
    import petf_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic resetn,
    // Set and clear requests.
    input  wire logic set_req,
    input  wire logic clr_req,
    // Flag state.
    output var  logic flag_q
);

    logic flag_d;

    // A set arriving with a clear is kept, so no event is lost.
    assign flag_d = set_req | (flag_q & ~clr_req);

    // Flag register.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flag_q <= RST_VAL;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

endmodule : petf_sticky_flag

`default_nettype wire

// ==== sim/petf_far_end_model.sv ====
// Interrupt controller and converter trigger inputs, counting pulses.
`default_nettype none

module petf_far_end_model
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic resetn,
    // Pulses arriving from the block.
    input  wire logic irq_pulse,
    input  wire logic conversion_start_a_pulse,
    input  wire logic conversion_start_b_pulse,
    // Pulse counts for the bench.
    output var  int   irq_n,
    output var  int   a_n,
    output var  int   b_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Sampled on every clock edge, so a pulse held two cycles would count twice.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_n <= 0;
            a_n   <= 0;
            b_n   <= 0;
        end
        else
        begin
            irq_n <= irq_n + int'(irq_pulse);
            a_n   <= a_n + int'(conversion_start_a_pulse);
            b_n   <= b_n + int'(conversion_start_b_pulse);
        end
    end
endmodule : petf_far_end_model

`default_nettype wire

// ==== sim/petf_trigger_flags_monitor.sv ====
// Port checks for the event-trigger flag block.
`default_nettype none

module petf_trigger_flags_monitor
    import petf_pkg::*;
(
    // Clock and reset.
    input wire logic               core_clk,
    input wire logic               resetn,
    // Register port.
    input wire logic [PETF_AW-1:0] reg_addr,
    input wire logic [PETF_DW-1:0] reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [PETF_DW-1:0] reg_rdata,
    // Events and pulses.
    input wire logic               irq_event_in,
    input wire logic               conversion_start_a_event_in,
    input wire logic               conversion_start_b_event_in,
    input wire logic               pwm_irq_output,
    input wire logic               conv_start_a_output,
    input wire logic               conv_start_b_output
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Write decodes feeding the shadow registers.
    logic wr_sel;
    logic wr_prd;
    logic wr_clr;
    logic wr_frc;
    assign wr_sel = reg_wr && reg_addr == PETF_SEL_OFS;
    assign wr_prd = reg_wr && reg_addr == PETF_PRESCALE_OFS;
    assign wr_clr = reg_wr && reg_addr == PETF_CLEAR_OFS;
    assign wr_frc = reg_wr && reg_addr == PETF_FORCE_OFS;

    // Shadows of enable, period and interrupt flag; set beats clear.
    logic       en_q;
    logic [1:0] prd_q;
    logic       blk_q;
    logic       flag_v;

    // The flag rises on the same edge as the pulse, so the pulse is ORed in.
    assign flag_v = pwm_irq_output || blk_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q  <= 1'h0;
            prd_q <= 2'h0;
            blk_q <= 1'h0;
        end
        else
        begin
            en_q  <= wr_sel ? reg_wdata[0] : en_q;
            prd_q <= wr_prd ? reg_wdata[1:0] : prd_q;
            blk_q <= (flag_v && !(wr_clr && reg_wdata[0]))
                     || (wr_frc && reg_wdata[0] && prd_q != 2'h0);
        end
    end

    // One event at period one fires on the next cycle.
    sequence fire_one_s;
        irq_event_in && prd_q == 2'h1 && en_q && !flag_v
            && !wr_prd;
    endsequence

    irq_width_a: assert property (
        pwm_irq_output |=> !pwm_irq_output)
        else $error("interrupt pulse wider than one cycle");
    irq_blocked_a: assert property (
        $past(flag_v) |-> !pwm_irq_output)
        else $error("interrupt pulse while flag set");
    period_zero_a: assert property (
        prd_q == 2'h0 && $past(prd_q) == 2'h0 |-> !pwm_irq_output)
        else $error("interrupt pulse with period zero");
    period_one_a: assert property (
        fire_one_s |=> pwm_irq_output)
        else $error("no interrupt on first event");
    irq_disabled_a: assert property (
        !en_q && !$past(en_q) |-> !pwm_irq_output)
        else $error("interrupt pulse while disabled");
    clear_reads_a: assert property (
        reg_rd && reg_addr == PETF_CLEAR_OFS |=> reg_rdata == '0)
        else $error("clear word reads nonzero");
    conv_a_cause_a: assert property (
        conv_start_a_output |-> $past(conversion_start_a_event_in)
            || $past(wr_frc && reg_wdata[2]))
        else $error("conversion A pulse without cause");
    conv_b_cause_a: assert property (
        conv_start_b_output |-> $past(conversion_start_b_event_in)
            || $past(wr_frc && reg_wdata[3]))
        else $error("conversion B pulse without cause");
endmodule : petf_trigger_flags_monitor

bind petf_trigger_flags petf_trigger_flags_monitor mon_u (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_event_in(irq_event_in),
    .conversion_start_a_event_in(conversion_start_a_event_in), .conversion_start_b_event_in(conversion_start_b_event_in),
    .pwm_irq_output(pwm_irq_output),
    .conv_start_a_output(conv_start_a_output),
    .conv_start_b_output(conv_start_b_output));

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the event-trigger flag block.
`default_nettype none

module tb
    import petf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               core_clk;
    logic               resetn;
    logic [PETF_AW-1:0] reg_addr;
    logic [PETF_DW-1:0] reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [PETF_DW-1:0] reg_rdata;
    logic               irq_ev;
    logic               a_ev;
    logic               b_ev;
    logic               irq_o;
    logic               a_o;
    logic               b_o;
    logic               flag_irq;
    int                 irq_n;
    int                 a_n;
    int                 b_n;
    int                 error_cnt = 0;
    int                 n_tests   = 0;

    petf_trigger_flags dut_u (.core_clk(core_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_event_in(irq_ev),
        .conversion_start_a_event_in(a_ev), .conversion_start_b_event_in(b_ev),
        .pwm_irq_output(irq_o), .conv_start_a_output(a_o),
        .conv_start_b_output(b_o), .flag_irq(flag_irq));
    petf_far_end_model model_u (.core_clk(core_clk), .resetn(resetn),
        .irq_pulse(irq_o), .conversion_start_a_pulse(a_o), .conversion_start_b_pulse(b_o),
        .irq_n(irq_n), .a_n(a_n), .b_n(b_n));

    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        n_tests++;
        if (got !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk

    // Bus tasks start and end just after a rising edge. A write leaves its
    // strobe up, so back-to-back writes never assign it twice in one step;
    // every other task lowers it as it starts, ev only when n is nonzero.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_wr   <= 1'h0;
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        chk(reg_rdata, e);
        @(posedge core_clk);
    endtask : rd

    task automatic idle(input int n);
        reg_wr <= 1'h0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic ev(input int n);
        repeat (n)
        begin
            reg_wr <= 1'h0;
            irq_ev <= 1'h1;
            @(posedge core_clk);
        end
        irq_ev <= 1'h0;
    endtask : ev

    // Each period needs exactly its count of events; tally shown first.
    task automatic t_periods;
        int b;
        wr(PETF_SEL_OFS, 16'h0001);
        for (int p = 1; p <= 3; p++)
        begin
            wr(PETF_PRESCALE_OFS, 16'(p));
            b = irq_n;
            ev(p - 1);
            idle(3);
            rd(PETF_PRESCALE_OFS, 16'(p + 4 * (p - 1)));
            chk(16'(irq_n), 16'(b));
            ev(1);
            idle(2);
            chk(16'(irq_n), 16'(b + 1));
            rd(PETF_PRESCALE_OFS, 16'(p));
            rd(PETF_FLAGS_OFS, 16'h0001);
            wr(PETF_CLEAR_OFS, 16'h0001);
        end
        $display("test periods done");
    endtask : t_periods

    // Back-to-back events: second is held until the flag is cleared.
    task automatic t_pending;
        int b;
        wr(PETF_PRESCALE_OFS, 16'h0001);
        b = irq_n;
        ev(2);
        idle(3);
        chk(16'(irq_n), 16'(b + 1));
        rd(PETF_PRESCALE_OFS, 16'h0015);
        wr(PETF_CLEAR_OFS, 16'h0001);
        idle(3);
        chk(16'(irq_n), 16'(b + 2));
        wr(PETF_CLEAR_OFS, 16'h0001);
        $display("test pending done");
    endtask : t_pending

    // Period rewrites, an event during the write, and period zero.
    task automatic t_prd_write;
        int b;
        wr(PETF_PRESCALE_OFS, 16'h0003);
        ev(2);
        b = irq_n;
        wr(PETF_PRESCALE_OFS, 16'h0002);
        idle(3);
        chk(16'(irq_n), 16'(b + 1));
        wr(PETF_CLEAR_OFS, 16'h0001);
        irq_ev <= 1'h1;
        wr(PETF_PRESCALE_OFS, 16'h0000);
        irq_ev <= 1'h0;
        wr(PETF_FORCE_OFS, 16'h0001);
        ev(3);
        idle(3);
        chk(16'(irq_n), 16'(b + 1));
        rd(PETF_PRESCALE_OFS, 16'h0004);
        rd(PETF_FLAGS_OFS, 16'h0000);
        $display("test period write done");
    endtask : t_prd_write

    // Conversion pulses keep coming while their flags are set.
    task automatic t_conv;
        int a;
        int b;
        a = a_n;
        b = b_n;
        wr(PETF_SEL_OFS, 16'h000C);
        wr(PETF_MASK_OFS, 16'h0004);
        a_ev <= 1'h1;
        idle(2);
        a_ev <= 1'h0;
        b_ev <= 1'h1;
        idle(1);
        b_ev <= 1'h0;
        idle(3);
        chk(16'(a_n), 16'(a + 2));
        chk(16'(b_n), 16'(b + 1));
        rd(PETF_FLAGS_OFS, 16'h000C);
        chk(16'(flag_irq), 16'h0001);
        wr(PETF_CLEAR_OFS, 16'h0004);
        idle(2);
        chk(16'(flag_irq), 16'h0000);
        rd(PETF_CLEAR_OFS, 16'h0000);
        rd(8'h20, 16'h0000);
        rd(PETF_SEL_OFS, 16'h000C);
        rd(PETF_MASK_OFS, 16'h0004);
        $display("test conversion done");
    endtask : t_conv

    // Disabled interrupt: tally parks at the period, nothing fires.
    task automatic t_disabled;
        int b;
        b = irq_n;
        wr(PETF_PRESCALE_OFS, 16'h0001);
        ev(2);
        idle(3);
        chk(16'(irq_n), 16'(b));
        rd(PETF_PRESCALE_OFS, 16'h0005);
        wr(PETF_FORCE_OFS, 16'h0001);
        idle(2);
        chk(16'(irq_n), 16'(b));
        rd(PETF_FLAGS_OFS, 16'h0009);
        $display("test disabled done");
    endtask : t_disabled

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial
    begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Hang guard: far beyond the length of the sequence.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        resetn    = 1'h0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        irq_ev    = 1'h0;
        a_ev      = 1'h0;
        b_ev      = 1'h0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'h1;
        idle(1);
        rd(PETF_FLAGS_OFS, 16'h0000);
        t_periods();
        t_pending();
        t_prd_write();
        t_conv();
        t_disabled();
        print_verdict();
    end
endmodule : tb

`default_nettype wire
